// file: src/ced_regs.vh
// constants for the coprocessor exception dispatch block
`ifndef CED_REGS_VH
`define CED_REGS_VH
`define CED_VEC_TRAP        8'h07
`define CED_VEC_PRIV        8'h08
`define CED_VEC_FLINE       8'h0B
`define CED_VEC_PROTO       8'h0D
`define CED_VEC_TRACE       8'h09
`define CED_VEC_ADDR_ERR    8'h03
`define CED_FMT_PRE4        2'h0
`define CED_FMT_POST6       2'h1
`define CED_FMT_MID10       2'h2
`define CED_FMT_FAULT       2'h3
`define CED_CAT_GENERAL     2'h0
`define CED_CAT_COND        2'h1
`define CED_CAT_SAVE        2'h2
`define CED_CAT_RESTORE     2'h3
`define CED_OPW_TYPE_HI     8
`define CED_OPW_TYPE_LO     6
`define CED_PRIM_FN_HI      13
`define CED_PRIM_FN_LO      8
`define CED_PRIM_CA_BIT     15
`define CED_PRIM_DR_BIT     13
`define CED_FN_SR_SCAN      6'h0E
`define CED_FN_SUPV_CHECK   6'h04
`define CED_FN_NULL         6'h02
`define CED_FN_PRE_EXC      6'h1C
`define CED_FN_MID_EXC      6'h1D
`define CED_FN_POST_EXC     6'h1E
`define CED_TRACE_OFF       2'h0
`define CED_TRACE_FLOW      2'h1
`define CED_TRACE_ALL       2'h2
`endif

// file: src/ced_dispatch.v
// coprocessor exception detection and dispatch toward the stacking sequencer
// Function
// - status/scan-pointer transfer in conditional instruction raises protocol violation.
// - that primitive with direction flag set under flow tracing makes trace pending.
// - odd value loaded into scan pointer takes an address error.
// - take-exception primitives select the exception by their own vector.
// - flagged primitive with come-again clear in conditional instruction is a protocol violation.
// - protocol violation writes nothing to the control interface register.
// - protocol violation uses mid-instruction frame and vector 13.
// - unmodified protocol violation return rereads the response interface register.
// - operation word type 110 or 111 gives F-line, no coprocessor traffic.
// - unmapped type 000-101 word gives F-line without control register write.
// - primitive incompatible with effective address mode gives F-line.
// - F-line from invalid primitive writes abort mask first.
// - bus error on the initiating access counts as absent coprocessor, F-line.
// - F-line uses four-word pre-instruction frame and vector 11, restarts instruction.
// - context save/restore in user state is a privilege violation before traffic.
// - supervisor check in user state writes abort mask, then privilege violation.
// - privilege violation uses four-word frame and vector 8.
// - true condition with null in conditional trap takes vector 7, six-word frame.
// - trace-all mode traces after every finished instruction.
// - flow mode traces after status change or non-sequential program counter.
// - pending trace does not alter save, restore or conditional communication.
// - primitive function bits all zeros or all ones is a protocol violation.
`timescale 1ns/10ps
`include "ced_regs.vh"
module ced_dispatch #(
    parameter VEC_W = 8
) (
    input  wire             clock_i,
    input  wire             reset_n_i,
    input  wire             clk_en_i,
    input  wire             opword_valid_i,
    input  wire [15:0]      opword_i,
    input  wire             opword_mapped_i,
    input  wire [1:0]       instr_category_i,
    input  wire             supervisor_i,
    input  wire [1:0]       trace_mode_i,
    input  wire             initial_access_i,
    input  wire             cir_bus_error_i,
    input  wire             prim_valid_i,
    input  wire [15:0]      prim_i,
    input  wire [VEC_W-1:0] prim_vector_i,
    input  wire             prim_ea_incompat_i,
    input  wire             prim_true_cond_i,
    input  wire             scan_load_i,
    input  wire [31:0]      scan_value_i,
    input  wire             instr_done_i,
    input  wire             flow_change_i,
    input  wire             exc_ack_i,
    output wire             start_comm_o,
    output wire             prim_accept_o,
    output reg              exc_req_o,
    output reg  [VEC_W-1:0] exc_vector_o,
    output reg  [1:0]       exc_frame_o,
    output reg              exc_abort_write_o,
    output reg              exc_reread_resp_o,
    output reg              trace_pending_o
);

    wire [5:0] fn = prim_i[`CED_PRIM_FN_HI:`CED_PRIM_FN_LO];
    wire       ca = prim_i[`CED_PRIM_CA_BIT];
    wire       dr = prim_i[`CED_PRIM_DR_BIT];
    wire       cond = (instr_category_i == `CED_CAT_COND);
    wire       ctx  = (instr_category_i == `CED_CAT_SAVE) || (instr_category_i == `CED_CAT_RESTORE);
    wire [2:0] otype = opword_i[`CED_OPW_TYPE_HI:`CED_OPW_TYPE_LO];
    // the direction flag shares bit 13 with the function field, so it is masked off here
    wire       scan_fn = ((fn & 6'h1F) == `CED_FN_SR_SCAN);

    // primitives that may not end a conditional instruction with come-again clear
    function flagged;
        input [5:0] f;
        begin
            flagged = (f == `CED_FN_SUPV_CHECK) || (f == 6'h01) || (f == 6'h03) || (f == 6'h05) ||
                      (f == 6'h06) || (f == 6'h07) || (f == 6'h08) || (f == 6'h10) || (f == 6'h11) ||
                      (f == 6'h0C) || (f == 6'h0D) || (f == 6'h0E);
        end
    endfunction

    reg             hit;
    reg [VEC_W-1:0] vec;
    reg [1:0]       frm;
    reg             abrt;
    reg             rr;
    reg             trc_set;

    always @* begin
        hit = 1'b0;
        vec = {VEC_W{1'b0}};
        frm = `CED_FMT_PRE4;
        abrt = 1'b0;
        rr = 1'b0;
        trc_set = 1'b0;
        if (opword_valid_i) begin
            if (otype[2:1] == 2'b11 || !opword_mapped_i) begin
                hit = 1'b1;
                vec = `CED_VEC_FLINE;
            end else if (ctx && !supervisor_i) begin
                hit = 1'b1;
                vec = `CED_VEC_PRIV;
            end
        end else if (initial_access_i && cir_bus_error_i) begin
            hit = 1'b1;
            vec = `CED_VEC_FLINE;
        end else if (prim_valid_i) begin
            if (fn == 6'h00 || fn == 6'h3F ||
                (cond && scan_fn) ||
                (cond && !ca && flagged(fn & 6'h1F))) begin
                hit = 1'b1;
                vec = `CED_VEC_PROTO;
                frm = `CED_FMT_MID10;
                abrt = 1'b0;
                rr = 1'b1;
            end else if (fn == `CED_FN_SUPV_CHECK && !supervisor_i) begin
                hit = 1'b1;
                vec = `CED_VEC_PRIV;
                abrt = 1'b1;
            end else if (prim_ea_incompat_i) begin
                hit = 1'b1;
                vec = `CED_VEC_FLINE;
                abrt = 1'b1;
            end else if (fn == `CED_FN_PRE_EXC || fn == `CED_FN_MID_EXC || fn == `CED_FN_POST_EXC) begin
                hit = 1'b1;
                vec = prim_vector_i;
                frm = (fn == `CED_FN_PRE_EXC) ? `CED_FMT_PRE4 :
                      (fn == `CED_FN_MID_EXC) ? `CED_FMT_MID10 : `CED_FMT_POST6;
            end else if (scan_fn && scan_load_i && scan_value_i[0]) begin
                hit = 1'b1;
                vec = `CED_VEC_ADDR_ERR;
                frm = `CED_FMT_FAULT;
            end else if (instr_category_i == `CED_CAT_COND && fn == `CED_FN_NULL && prim_true_cond_i) begin
                hit = 1'b1;
                vec = `CED_VEC_TRAP;
                frm = `CED_FMT_POST6;
            end
            if (scan_fn && dr && trace_mode_i == `CED_TRACE_FLOW)
                trc_set = 1'b1;
        end
    end

    // trace pending never stalls coprocessor communication
    assign start_comm_o  = opword_valid_i && !hit && !exc_req_o;
    assign prim_accept_o = prim_valid_i && !exc_req_o;

    wire trace_now = instr_done_i &&
                     ((trace_mode_i == `CED_TRACE_ALL) ||
                      (trace_mode_i == `CED_TRACE_FLOW && (flow_change_i || trace_pending_o)));

    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exc_req_o         <= 1'b0;
            exc_vector_o      <= {VEC_W{1'b0}};
            exc_frame_o       <= `CED_FMT_PRE4;
            exc_abort_write_o <= 1'b0;
            exc_reread_resp_o <= 1'b0;
            trace_pending_o   <= 1'b0;
        end else if (clk_en_i) begin
            if (exc_req_o) begin
                if (exc_ack_i)
                    exc_req_o <= 1'b0;
            end else if (hit && !instr_done_i) begin
                exc_req_o         <= 1'b1;
                exc_vector_o      <= vec;
                exc_frame_o       <= frm;
                exc_abort_write_o <= abrt;
                exc_reread_resp_o <= rr;
            end else if (trace_now) begin
                exc_req_o         <= 1'b1;
                exc_vector_o      <= `CED_VEC_TRACE;
                exc_frame_o       <= `CED_FMT_POST6;
                exc_abort_write_o <= 1'b0;
                exc_reread_resp_o <= 1'b0;
            end
            if (trc_set && !exc_req_o)
                trace_pending_o <= 1'b1;
            else if (instr_done_i && !exc_req_o)
                trace_pending_o <= 1'b0;
        end
    end

endmodule

// file: verif/ced_dispatch_sva.sv
// checker of the exception request ports
`timescale 1ns/10ps
module ced_dispatch_chk #(parameter VEC_W = 8) (
    input wire             clock_i,
    input wire             reset_n_i,
    input wire             clk_en_i,
    input wire             opword_valid_i,
    input wire [15:0]      opword_i,
    input wire             cir_bus_error_i,
    input wire             prim_valid_i,
    input wire [15:0]      prim_i,
    input wire             exc_ack_i,
    input wire             start_comm_o,
    input wire             exc_req_o,
    input wire [VEC_W-1:0] exc_vector_o,
    input wire [1:0]       exc_frame_o,
    input wire             exc_abort_write_o,
    input wire             exc_reread_resp_o
);
    wire go = clk_en_i && !exc_req_o;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    req_hold_a: assert property (exc_req_o && !exc_ack_i |=> exc_req_o && $stable(exc_vector_o))
        else $error("hold");
    ack_drop_a: assert property (exc_req_o && exc_ack_i |=> !exc_req_o) else $error("drop");
    proto_frame_a: assert property ($rose(exc_req_o) && exc_vector_o == 8'h0D |->
        exc_frame_o == 2'h2 && !exc_abort_write_o && exc_reread_resp_o) else $error("proto");
    fline_frame_a: assert property ($rose(exc_req_o) && exc_vector_o == 8'h0B |-> exc_frame_o == 2'h0)
        else $error("fline");
    priv_frame_a: assert property ($rose(exc_req_o) && exc_vector_o == 8'h08 |-> exc_frame_o == 2'h0)
        else $error("priv");
    trap_frame_a: assert property ($rose(exc_req_o) && exc_vector_o == 8'h07 |-> exc_frame_o == 2'h1)
        else $error("trap");
    opword_fline_a: assert property (go && opword_valid_i && opword_i[8:7] == 2'h3 |-> !start_comm_o ##1
        exc_req_o && exc_vector_o == 8'h0B && !exc_abort_write_o) else $error("type");
    bad_function_a: assert property (go && prim_valid_i && !opword_valid_i && !cir_bus_error_i &&
        (prim_i[13:8] == 6'h00 || prim_i[13:8] == 6'h3F) |=> exc_vector_o == 8'h0D) else $error("func");
endmodule
bind ced_dispatch ced_dispatch_chk #(.VEC_W(VEC_W)) u_chk (.*);

// file: verif/ced_copro_model.sv
// coprocessor model answering each primitive read after a chosen delay
`timescale 1ns/10ps
module ced_copro_model (
    input  wire        clock_i,
    input  wire        ask_i,
    input  wire [15:0] word_i,
    input  wire [2:0]  delay_i,
    output reg         prim_valid_o = 1'h0,
    output reg  [15:0] prim_o = 16'h0000
);
    reg [3:0]  wait_q = 4'h0;
    reg [15:0] word_q = 16'h0000;
    always @(posedge clock_i) begin
        prim_valid_o <= wait_q == 4'h1;
        prim_o <= (wait_q == 4'h1) ? word_q : ~prim_o; // word holds the primitive the bench asked for only while valid; otherwise it inverts every cycle
        if (ask_i) begin
            wait_q <= {1'h0, delay_i} + 4'h1;
            word_q <= word_i;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end
    end
endmodule

// file: verif/test_ced_dispatch.sv
// self-checking bench for the exception dispatch block
`timescale 1ns/10ps
module test_ced_dispatch;
    reg         clock_i = 1'h0, reset_n_i = 1'h0, clk_en_i = 1'h1, initial_access_i = 1'h1, flow_change_i = 1'h0;
    reg         opword_valid_i = 1'h0, opword_mapped_i = 1'h1, supervisor_i = 1'h0, cir_bus_error_i = 1'h0;
    reg         prim_ea_incompat_i = 1'h0, prim_true_cond_i = 1'h0, scan_load_i = 1'h0, instr_done_i = 1'h0;
    reg         exc_ack_i = 1'h0, ask = 1'h0;
    reg  [1:0]  instr_category_i = 2'h0, trace_mode_i = 2'h0;
    reg  [7:0]  prim_vector_i = 8'h00;
    reg  [15:0] opword_i = 16'h0000;
    reg  [31:0] scan_value_i = 32'h0, seed = 32'h0C004F30, r = 32'h0;
    reg  [11:0] exp_q[$];
    wire        prim_valid_i, start_comm_o, prim_accept_o, exc_req_o, exc_abort_write_o, exc_reread_resp_o;
    wire        trace_pending_o;
    wire [15:0] prim_i;
    wire [7:0]  exc_vector_o;
    wire [1:0]  exc_frame_o;
    integer     n_errors = 0, tests_run = 0, cyc = 0, i, j;
    ced_dispatch u_dut (.*);
    ced_copro_model u_cop (.clock_i(clock_i), .ask_i(ask), .word_i(opword_i), .delay_i(r[2:0]),
        .prim_valid_o(prim_valid_i), .prim_o(prim_i));
    always #2.5 clock_i = ~clock_i;
    task test_done; begin
        if (n_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end endtask
    // one event, its expected request noted first
    task ev(input [3:0] k, input [15:0] w, input [11:0] e); begin
        r = $random(seed);
        if (e != 12'h000) exp_q.push_back(e);
        opword_i <= w;
        {instr_done_i, ask, cir_bus_error_i, opword_valid_i} <= k;
        @(posedge clock_i);
        {instr_done_i, ask, cir_bus_error_i, opword_valid_i} <= 4'h0;
        for (i = 0; i < 30 && (i < 3 || exp_q.size() != 0 || exc_req_o); i = i + 1) @(posedge clock_i);
        repeat (2) @(posedge clock_i);
    end endtask
    always @(posedge clock_i) begin
        exc_ack_i <= 1'h0;
        cyc = cyc + 1;
        if (cyc > 2000) begin
            n_errors = n_errors + 1;
            test_done;
        end
        if (exc_req_o === 1'h1 && exc_ack_i === 1'h0) begin
            tests_run = tests_run + 1;
            if (exp_q.size() == 0 || {exc_vector_o, exc_frame_o, exc_abort_write_o, exc_reread_resp_o} !== exp_q[0]) begin
                n_errors = n_errors + 1;
                $display("mismatch %0t vector %h frame %h", $time, exc_vector_o, exc_frame_o);
            end
            if (exp_q.size() != 0) exp_q.delete(0);
            exc_ack_i <= 1'h1;
        end
    end
    initial begin
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1'h1;
        for (j = 6; j < 8; j = j + 1) ev(4'h1, {7'h78, j[2:0], r[5:0]}, 12'h0B0);
        opword_mapped_i <= 1'h0;
        ev(4'h1, {7'h78, 1'h0, r[1:0], r[5:0]}, 12'h0B0);
        opword_mapped_i <= 1'h1;
        for (j = 2; j < 4; j = j + 1) begin
            instr_category_i <= j[1:0];
            ev(4'h1, 16'hF000, 12'h080);
        end
        instr_category_i <= 2'h0;
        ev(4'h2, 16'h0000, 12'h0B0);
        for (j = 0; j < 2; j = j + 1) ev(4'h4, {2'h2, {6{j[0]}}, r[7:0]}, 12'h0D9);
        ev(4'h4, 16'h8400, 12'h082);
        prim_ea_incompat_i <= 1'h1;
        ev(4'h4, 16'h8100, 12'h0B2);
        prim_ea_incompat_i <= 1'h0;
        for (j = 0; j < 3; j = j + 1) begin
            prim_vector_i <= {2'h1, r[5:0]};
            ev(4'h4, {8'h9C + j[7:0], 8'h00}, {2'h1, r[5:0], j[0], j[1], 2'h0});
        end
        scan_load_i <= 1'h1;
        scan_value_i <= r | 32'h1;
        ev(4'h4, 16'h8E00, 12'h03C);
        scan_load_i <= 1'h0;
        instr_category_i <= 2'h1;
        ev(4'h4, 16'h8E00, 12'h0D9);
        ev(4'h4, 16'h0400, 12'h0D9);
        prim_true_cond_i <= 1'h1;
        ev(4'h4, 16'h0200, 12'h074);
        instr_category_i <= 2'h0;
        trace_mode_i <= 2'h1;
        ev(4'h4, 16'hAE00, 12'h000);
        repeat (12) @(posedge clock_i);
        tests_run = tests_run + 1;
        if (trace_pending_o !== 1'h1) begin
            n_errors = n_errors + 1;
            $display("mismatch %0t trace not pending", $time);
        end
        ev(4'h8, 16'h0000, 12'h094);
        flow_change_i <= 1'h1;
        ev(4'h8, 16'h0000, 12'h094);
        flow_change_i <= 1'h0;
        trace_mode_i <= 2'h2;
        ev(4'h8, 16'h0000, 12'h094);
        test_done;
    end
endmodule
